// ---- rtl/spf_pkg.sv ----
// constants, register map and types of the slow port filter block
package spf_pkg;
  localparam logic [11:0] SPF_RX_CMD_OFS  = 12'h000;
  localparam logic [11:0] SPF_RX_STS_OFS  = 12'h004;
  localparam logic [11:0] SPF_TX_LEN_OFS  = 12'h008;
  localparam logic [11:0] SPF_HDR_VAL_OFS = 12'h010;
  localparam logic [11:0] SPF_HDR_EN_OFS  = 12'h040;
  localparam logic [11:0] SPF_USR_CMD_OFS = 12'h080;
  localparam logic [11:0] SPF_USR_INT_OFS = 12'h084;
  localparam logic [11:0] SPF_USR_RST_OFS = 12'h088;
  localparam logic [11:0] SPF_TX_CNT_OFS  = 12'h08C;
  localparam logic [11:0] SPF_RX_CNT_OFS  = 12'h090;
  localparam logic [11:0] SPF_USR_FF_OFS  = 12'h094;
  localparam logic [5:0]  SPF_RX_RAM_PAGE = 6'h10;
  localparam logic [5:0]  SPF_TX_RAM_PAGE = 6'h20;

  localparam int SPF_HDR_BYTES = 38;
  localparam int SPF_HDR_WORDS = 10;
  localparam int SPF_RAM_BYTES = 64;

  localparam int SPF_RX_EN_BIT    = 0;
  localparam int SPF_RX_ACK_BIT   = 1;
  localparam int SPF_RX_EMPTY_BIT = 15;
  localparam int SPF_TX_BUSY_BIT  = 31;
  localparam int SPF_GEN_BIT      = 0;
  localparam int SPF_VER_BIT      = 1;
  localparam int SPF_CONN_BIT     = 2;
  localparam int SPF_CEV_BIT      = 0;
  localparam int SPF_PRST_BIT     = 0;
  localparam int SPF_LINK_BIT     = 16;

  localparam logic [6:0] SPF_ETYPE_HI_POS = 7'h0C;
  localparam logic [6:0] SPF_ETYPE_LO_POS = 7'h0D;
  localparam logic [7:0] SPF_ETYPE_HI     = 8'h08;
  localparam logic [7:0] SPF_ETYPE_LO     = 8'h00;

  // reset defaults program the echo request filter, own address zero
  localparam logic [31:0] SPF_HDR_VAL_RST [SPF_HDR_WORDS] = '{
    32'h0, 32'h0, 32'h0, 32'h0045_0008, 32'h0,
    32'h0100_0000, 32'h0, 32'h0, 32'h0008_0000, 32'h0};
  localparam logic [31:0] SPF_HDR_EN_RST [SPF_HDR_WORDS] = '{
    32'h0, 32'h0, 32'h0, 32'h0001_0101, 32'h0,
    32'h0100_0000, 32'h0, 32'h0101_0000, 32'h0101_0101, 32'h0};

  typedef enum logic [1:0] {
    SPF_RX_IDLE = 2'b00,
    SPF_RX_CAPT = 2'b01,
    SPF_RX_DROP = 2'b11
  } spf_rx_st_t;
endpackage

// ---- rtl/spf_top.sv ----
// slow port frame filter, packet rams and fast port user registers
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps

module spf_top #(
  parameter int PAT_W = 32
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic [11:0]       reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_last,
  output logic                   tx_valid,
  output logic      [7:0]        tx_data,
  output logic                   tx_last,
  input  wire logic              tx_ready,
  input  wire logic              link_up,
  input  wire logic              conn_on,
  input  wire logic              conn_event,
  input  wire logic [15:0]       fast_fifo_count,
  output logic                   gen_valid,
  output logic      [PAT_W-1:0]  gen_data,
  input  wire logic              gen_ready,
  input  wire logic              chk_valid,
  input  wire logic [PAT_W-1:0]  chk_data
);
  localparam logic [31:0] PAT_BYTES = 32'(PAT_W / 8);
  logic [31:0]         hdr_val_r [spf_pkg::SPF_HDR_WORDS];
  logic [31:0]         hdr_en_r  [spf_pkg::SPF_HDR_WORDS];
  logic [7:0]          rx_ram_r  [spf_pkg::SPF_RAM_BYTES];
  logic [7:0]          tx_ram_r  [spf_pkg::SPF_RAM_BYTES];
  logic                rx_en_r;
  logic                desc_vld_r;
  logic [5:0]          desc_last_r;
  spf_pkg::spf_rx_st_t rx_st_r;
  logic [6:0]          rx_idx_r;
  logic                rx_match_r;
  logic                tx_busy_r;
  logic [6:0]          tx_len_r;
  logic [6:0]          tx_ptr_r;
  logic [7:0]          tx_data_r;
  logic                gen_run_r;
  logic                ver_en_r;
  logic                err_r;
  logic                cev_r;
  logic [PAT_W-1:0]    gen_data_r;
  logic [PAT_W-1:0]    exp_r;
  logic [31:0]         tx_cnt_r;
  logic [31:0]         rx_cnt_r;
  logic [31:0]         rd_nxt;
  logic [31:0]         reg_rdata_r;
  logic       wr_rx_cmd;
  logic       wr_tx_len;
  logic       wr_usr_cmd;
  logic       wr_usr_int;
  logic       wr_usr_rst;
  logic       hv_sel;
  logic       he_sel;
  logic [3:0] hv_idx;
  logic [3:0] he_idx;
  logic       tx_ram_sel;
  logic       rx_ram_sel;
  logic [6:0] idx_cur;
  logic       cap_go;
  logic       byte_ok;
  logic       match_cur;
  logic [7:0] hdr_byte;
  logic       hdr_en;
  logic       push;
  logic       tx_start;
  logic       tx_hs;
  logic       pop;
  assign wr_rx_cmd  = reg_wr && reg_addr == spf_pkg::SPF_RX_CMD_OFS;
  assign wr_tx_len  = reg_wr && reg_addr == spf_pkg::SPF_TX_LEN_OFS;
  assign wr_usr_cmd = reg_wr && reg_addr == spf_pkg::SPF_USR_CMD_OFS;
  assign wr_usr_int = reg_wr && reg_addr == spf_pkg::SPF_USR_INT_OFS;
  assign wr_usr_rst = reg_wr && reg_addr == spf_pkg::SPF_USR_RST_OFS;
  assign hv_idx     = 4'((reg_addr - spf_pkg::SPF_HDR_VAL_OFS) >> 2);
  assign he_idx     = 4'((reg_addr - spf_pkg::SPF_HDR_EN_OFS) >> 2);
  // full-width bound: a cut index would alias the counters and the rams
  assign hv_sel     = reg_addr >= spf_pkg::SPF_HDR_VAL_OFS && reg_addr[1:0] == 2'h0 &&
                      reg_addr < spf_pkg::SPF_HDR_VAL_OFS + 12'(4 * spf_pkg::SPF_HDR_WORDS);
  assign he_sel     = reg_addr >= spf_pkg::SPF_HDR_EN_OFS && reg_addr[1:0] == 2'h0 &&
                      reg_addr < spf_pkg::SPF_HDR_EN_OFS + 12'(4 * spf_pkg::SPF_HDR_WORDS);
  assign tx_ram_sel = reg_addr[11:6] == spf_pkg::SPF_TX_RAM_PAGE;
  assign rx_ram_sel = reg_addr[11:6] == spf_pkg::SPF_RX_RAM_PAGE;
  // header programming registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hdr_val_r <= spf_pkg::SPF_HDR_VAL_RST;
      hdr_en_r  <= spf_pkg::SPF_HDR_EN_RST;
    end else if (reg_wr) begin
      if (hv_sel) begin
        hdr_val_r[hv_idx] <= reg_wdata;
      end
      if (he_sel) begin
        hdr_en_r[he_idx] <= reg_wdata;
      end
    end
  end
  // filter: one compare per incoming byte, decision at the last byte
  assign idx_cur  = (rx_st_r == spf_pkg::SPF_RX_IDLE) ? 7'h00 : rx_idx_r;
  assign cap_go   = rx_valid && (rx_st_r == spf_pkg::SPF_RX_CAPT ||
                    (rx_st_r == spf_pkg::SPF_RX_IDLE && rx_en_r && !desc_vld_r));
  assign hdr_byte = (idx_cur < 7'(spf_pkg::SPF_HDR_BYTES)) ?
                    hdr_val_r[idx_cur[5:2]][{idx_cur[1:0], 3'b000} +: 8] : 8'h00;
  assign hdr_en   = (idx_cur < 7'(spf_pkg::SPF_HDR_BYTES)) &&
                    hdr_en_r[idx_cur[5:2]][{idx_cur[1:0], 3'b000}];
  always_comb begin
    byte_ok = !hdr_en || rx_data == hdr_byte;
    if (idx_cur == spf_pkg::SPF_ETYPE_HI_POS) begin
      byte_ok = byte_ok && rx_data == spf_pkg::SPF_ETYPE_HI;
    end
    if (idx_cur == spf_pkg::SPF_ETYPE_LO_POS) begin
      byte_ok = byte_ok && rx_data == spf_pkg::SPF_ETYPE_LO;
    end
  end
  // overlong and short frames fail: short ones would skip enabled bytes
  assign match_cur = (idx_cur == 7'h00 || rx_match_r) && byte_ok && !idx_cur[6];
  assign push      = cap_go && rx_last && match_cur &&
                     idx_cur >= 7'(spf_pkg::SPF_HDR_BYTES - 1);
  assign pop       = wr_rx_cmd && reg_wdata[spf_pkg::SPF_RX_ACK_BIT];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_st_r    <= spf_pkg::SPF_RX_IDLE;
      rx_idx_r   <= 7'h00;
      rx_match_r <= 1'b0;
    end else if (rx_valid) begin
      unique case (rx_st_r)
        spf_pkg::SPF_RX_IDLE: begin
          if (!rx_last) begin
            rx_st_r <= cap_go ? spf_pkg::SPF_RX_CAPT : spf_pkg::SPF_RX_DROP;
          end
        end
        spf_pkg::SPF_RX_CAPT, spf_pkg::SPF_RX_DROP: begin
          if (rx_last) begin
            rx_st_r <= spf_pkg::SPF_RX_IDLE;
          end
        end
      endcase
      rx_idx_r   <= idx_cur[6] ? idx_cur : idx_cur + 7'h01;
      rx_match_r <= match_cur;
    end
  end
  // one stored frame at a time, always from ram address zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_en_r     <= 1'b0;
      desc_vld_r  <= 1'b0;
      desc_last_r <= 6'h00;
    end else begin
      if (wr_rx_cmd) begin
        rx_en_r <= reg_wdata[spf_pkg::SPF_RX_EN_BIT];
      end
      if (push) begin
        desc_vld_r  <= 1'b1;
        desc_last_r <= idx_cur[5:0];
      end else if (pop) begin
        desc_vld_r <= 1'b0;
      end
    end
  end
  // storage; rejected bytes only land in space no descriptor points at
  for (genvar i = 0; i < spf_pkg::SPF_RAM_BYTES; i++) begin : g_ram
    always_ff @(posedge clock) begin
      if (cap_go && !idx_cur[6] && idx_cur[5:0] == 6'(i)) begin
        rx_ram_r[i] <= rx_data;
      end
      if (reg_wr && tx_ram_sel && reg_addr[5:2] == 4'(i / 4)) begin
        tx_ram_r[i] <= reg_wdata[8 * (i % 4) +: 8];
      end
    end
  end
  // transmit: length write launches; zero, overlong or busy writes ignored
  assign tx_start = wr_tx_len && !tx_busy_r && reg_wdata[6:0] != 7'h00 &&
                    reg_wdata[31:7] == 25'h0 && reg_wdata[6:0] <= 7'(spf_pkg::SPF_RAM_BYTES);
  assign tx_hs    = tx_busy_r && tx_ready;
  assign tx_valid = tx_busy_r;
  assign tx_data  = tx_data_r;
  assign tx_last  = tx_busy_r && tx_ptr_r + 7'h01 == tx_len_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_busy_r <= 1'b0;
      tx_len_r  <= 7'h00;
      tx_ptr_r  <= 7'h00;
      tx_data_r <= 8'h00;
    end else if (tx_start) begin
      tx_busy_r <= 1'b1;
      tx_len_r  <= reg_wdata[6:0];
      tx_ptr_r  <= 7'h00;
      tx_data_r <= tx_ram_r[0];
    end else if (tx_hs) begin
      tx_ptr_r  <= tx_ptr_r + 7'h01;
      tx_data_r <= tx_ram_r[6'(tx_ptr_r + 7'h01)];
      if (tx_last) begin
        tx_busy_r <= 1'b0;
      end
    end
  end
  // pattern generator and checker of the fast port
  assign gen_valid = gen_run_r;
  assign gen_data  = gen_data_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gen_run_r <= 1'b0;
      ver_en_r  <= 1'b0;
    end else if (wr_usr_cmd) begin
      gen_run_r <= reg_wdata[spf_pkg::SPF_GEN_BIT];
      ver_en_r  <= reg_wdata[spf_pkg::SPF_VER_BIT];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gen_data_r <= '0;
      exp_r      <= '0;
      err_r      <= 1'b0;
      tx_cnt_r   <= 32'h0;
      rx_cnt_r   <= 32'h0;
    end else if (wr_usr_rst && reg_wdata[spf_pkg::SPF_PRST_BIT]) begin
      gen_data_r <= '0;
      exp_r      <= '0;
      err_r      <= 1'b0;
      tx_cnt_r   <= 32'h0;
      rx_cnt_r   <= 32'h0;
    end else begin
      if (gen_valid && gen_ready) begin
        gen_data_r <= gen_data_r + 1'b1;
        tx_cnt_r   <= tx_cnt_r + PAT_BYTES;
      end
      if (chk_valid) begin
        exp_r    <= exp_r + 1'b1;
        rx_cnt_r <= rx_cnt_r + PAT_BYTES;
        if (ver_en_r && chk_data != exp_r) begin
          err_r <= 1'b1;
        end
      end
    end
  end
  // sticky event: a new event beats a clear in the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cev_r <= 1'b0;
    end else if (conn_event) begin
      cev_r <= 1'b1;
    end else if (wr_usr_int && reg_wdata[spf_pkg::SPF_CEV_BIT]) begin
      cev_r <= 1'b0;
    end
  end
  // read mux, unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0;
    if (hv_sel) begin
      rd_nxt = hdr_val_r[hv_idx];
    end else if (he_sel) begin
      rd_nxt = hdr_en_r[he_idx];
    end else if (rx_ram_sel) begin
      rd_nxt = {rx_ram_r[{reg_addr[5:2], 2'b11}], rx_ram_r[{reg_addr[5:2], 2'b10}],
                rx_ram_r[{reg_addr[5:2], 2'b01}], rx_ram_r[{reg_addr[5:2], 2'b00}]};
    end else if (tx_ram_sel) begin
      rd_nxt = {tx_ram_r[{reg_addr[5:2], 2'b11}], tx_ram_r[{reg_addr[5:2], 2'b10}],
                tx_ram_r[{reg_addr[5:2], 2'b01}], tx_ram_r[{reg_addr[5:2], 2'b00}]};
    end else begin
      case (reg_addr)
        spf_pkg::SPF_RX_CMD_OFS: rd_nxt[spf_pkg::SPF_RX_EN_BIT] = rx_en_r;
        spf_pkg::SPF_RX_STS_OFS: begin
          rd_nxt[spf_pkg::SPF_RX_EMPTY_BIT] = !desc_vld_r;
          rd_nxt[5:0] = desc_last_r;
        end
        spf_pkg::SPF_TX_LEN_OFS: begin
          rd_nxt[spf_pkg::SPF_TX_BUSY_BIT] = tx_busy_r;
          rd_nxt[6:0] = tx_len_r;
        end
        spf_pkg::SPF_USR_CMD_OFS: begin
          rd_nxt[spf_pkg::SPF_GEN_BIT]  = gen_run_r;
          rd_nxt[spf_pkg::SPF_VER_BIT]  = err_r;
          rd_nxt[spf_pkg::SPF_CONN_BIT] = conn_on;
        end
        spf_pkg::SPF_USR_INT_OFS: rd_nxt[spf_pkg::SPF_CEV_BIT] = cev_r;
        spf_pkg::SPF_USR_RST_OFS: rd_nxt[spf_pkg::SPF_LINK_BIT] = link_up;
        spf_pkg::SPF_TX_CNT_OFS:  rd_nxt = tx_cnt_r;
        spf_pkg::SPF_RX_CNT_OFS:  rd_nxt = rx_cnt_r;
        spf_pkg::SPF_USR_FF_OFS:  rd_nxt[15:0] = fast_fifo_count;
        default:                  rd_nxt = 32'h0;
      endcase
    end
  end
  // data valid only in the cycle after the strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata_r <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_nxt;
    end else begin
      reg_rdata_r <= 32'h0;
    end
  end
  assign reg_rdata = reg_rdata_r;
  // per-byte agreement of the stored frame with the programmed header
  logic [spf_pkg::SPF_HDR_BYTES-1:0] ok_vec;
  for (genvar b = 0; b < spf_pkg::SPF_HDR_BYTES; b++) begin : g_ok
    assign ok_vec[b] = !hdr_en_r[b / 4][8 * (b % 4)] ||
                       rx_ram_r[b] == hdr_val_r[b / 4][8 * (b % 4) +: 8];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_ETYPE: assert property ($rose(desc_vld_r) |-> rx_ram_r[12] == spf_pkg::SPF_ETYPE_HI &&
    rx_ram_r[13] == spf_pkg::SPF_ETYPE_LO) else $error("stored frame has wrong type");
  AST_HDR_MATCH: assert property ($rose(desc_vld_r) && !$past(reg_wr) |-> &ok_vec)
    else $error("stored frame fails header compare");
  AST_NO_CAP: assert property (rx_st_r == spf_pkg::SPF_RX_IDLE && rx_valid && !rx_en_r
    |=> rx_st_r != spf_pkg::SPF_RX_CAPT && !$rose(desc_vld_r)) else $error("capture while off");
  AST_EMPTY: assert property (reg_rd && reg_addr == spf_pkg::SPF_RX_STS_OFS
    |=> reg_rdata[15] == !$past(desc_vld_r)) else $error("empty flag wrong");
  AST_LAST: assert property (reg_rd && reg_addr == spf_pkg::SPF_RX_STS_OFS
    |=> reg_rdata[5:0] == $past(desc_last_r)) else $error("last address wrong");
  AST_POP: assert property (pop && !push && desc_vld_r |=> !desc_vld_r ##1 !desc_vld_r [*1])
    else $error("descriptor not popped");
  AST_TX_START: assert property (tx_start |=> tx_valid && tx_data == $past(tx_ram_r[0])
    && tx_len_r == $past(reg_wdata[6:0])) else $error("transmit did not start");
  AST_CONN: assert property (reg_rd && reg_addr == spf_pkg::SPF_USR_CMD_OFS
    |=> reg_rdata[2] == $past(conn_on)) else $error("connection bit wrong");
  AST_LINK: assert property (reg_rd && reg_addr == spf_pkg::SPF_USR_RST_OFS
    |=> reg_rdata[16] == $past(link_up)) else $error("link bit wrong");
  AST_CEV: assert property (conn_event |=> cev_r) else $error("event lost");
  AST_PRST: assert property (wr_usr_rst && reg_wdata[0] |=> gen_data_r == '0 &&
    exp_r == '0 && tx_cnt_r == 32'h0) else $error("pattern not restarted");
  AST_START: assert property (wr_usr_cmd && reg_wdata[0] |=> gen_valid &&
    ver_en_r == $past(reg_wdata[1])) else $error("generator not started");
  AST_TXCNT: assert property (gen_valid && gen_ready && !wr_usr_rst
    |=> tx_cnt_r == $past(tx_cnt_r) + PAT_BYTES) else $error("transmit count wrong");
  COV_PUSH: cover property ($rose(desc_vld_r) ##[1:200] pop);
  COV_TX:   cover property (tx_start ##[1:100] (tx_hs && tx_last));
  COV_ERR:  cover property ($rose(err_r));
endmodule

// ---- tb/spf_mac_model.sv ----
// mac stream partner: frame source for rx and paced byte sink for tx
`timescale 1ns/100ps
module spf_mac_model (
  input  wire logic       clock,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_last
);
  logic [7:0] txq [$];
  int         last_at = 0;
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
  end
  // slow sink stalls every other cycle, like a congested mac
  always @(posedge clock) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      txq.push_back(tx_data);
      if (tx_last) last_at = txq.size();
    end
  end
  task automatic send(input logic [7:0] f [64], input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= f[i];
      rx_last  <= (i == len - 1);
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    // idle line must not repeat the last byte
    rx_data  <= ~f[len-1];
    rx_last  <= 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the slow port filter block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        rx_valid, rx_last, tx_valid, tx_last, tx_ready, gen_valid;
  logic [7:0]  rx_data, tx_data;
  logic        link_up = 1'b0, conn_on = 1'b0, conn_event = 1'b0, slow = 1'b0;
  logic [15:0] fast_fifo_count = 16'h0000;
  logic [31:0] gen_data;
  logic        gen_ready = 1'b0, chk_valid = 1'b0;
  logic [31:0] chk_data = 32'h0;
  logic [7:0]  frm [64];
  int          n_errors = 0, samples_checked = 0, cycles = 0;

  spf_top #(.PAT_W(32)) dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .link_up(link_up),
    .conn_on(conn_on), .conn_event(conn_event), .fast_fifo_count(fast_fifo_count),
    .gen_valid(gen_valid), .gen_data(gen_data), .gen_ready(gen_ready),
    .chk_valid(chk_valid), .chk_data(chk_data));
  spf_mac_model mac (.clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last));

  always #10 clock = ~clock;
  // whole run needs under a thousand cycles; a hang stops here
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[FAIL] timeout expected done seen hang");
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic mk(input logic [31:0] ip);
    for (int i = 0; i < 64; i++) frm[i] = 8'h40 + i[7:0];
    {frm[12], frm[13], frm[14]} = 24'h080045;
    frm[23] = 8'h01;
    {frm[30], frm[31], frm[32], frm[33]} = ip;
    {frm[34], frm[35]} = 16'h0800;
  endtask
  task automatic rx_try(input int len, input logic ok);
    logic [31:0] d;
    mac.send(frm, len);
    rd(spf_pkg::SPF_RX_STS_OFS, d);
    `CHK("rx_empty", !ok, d[15])
    if (ok) begin
      `CHK("rx_last_addr", 6'(len - 1), d[5:0])
      wr(spf_pkg::SPF_RX_CMD_OFS, 32'h0000_0003);
      rd(spf_pkg::SPF_RX_STS_OFS, d);
      `CHK("rx_empty_pop", 1'b1, d[15])
    end
  endtask
  task automatic chk(input logic [31:0] w);
    @(posedge clock);
    chk_valid <= 1'b1;
    chk_data <= w;
    @(posedge clock);
    chk_valid <= 1'b0;
    chk_data <= ~w;
  endtask

  task automatic t_regs();
    logic [31:0] d;
    rd(spf_pkg::SPF_RX_STS_OFS, d);
    `CHK("rst_empty", 1'b1, d[15])
    rd(spf_pkg::SPF_HDR_EN_OFS + 12'h00C, d);
    `CHK("rst_hdr_en3", 32'h0001_0101, d)
    wr(12'hFFC, 32'hFFFF_FFFF);
    rd(12'hFFC, d);
    `CHK("unmapped", 32'h0, d)
  endtask
  task automatic t_rx();
    logic [31:0] d;
    mk(32'h0);
    wr(spf_pkg::SPF_RX_CMD_OFS, 32'h0);
    rx_try(42, 1'b0);
    wr(spf_pkg::SPF_RX_CMD_OFS, 32'h1);
    rx_try(42, 1'b1);
    rd({spf_pkg::SPF_RX_RAM_PAGE, 6'h08}, d);
    `CHK("rx_ram", {frm[11], frm[10], frm[9], frm[8]}, d)
    rx_try(38, 1'b1);
    rx_try(37, 1'b0);
    frm[38] = ~frm[38];
    rx_try(42, 1'b1);
  endtask
  task automatic t_filter();
    int pos [7] = '{12, 13, 14, 23, 30, 34, 35};
    for (int k = 0; k < 7; k++) begin
      mk(32'h0);
      frm[pos[k]] ^= 8'h01;
      rx_try(42, 1'b0);
    end
    wr(spf_pkg::SPF_HDR_VAL_OFS + 12'h01C, 32'hA8C0_0000);
    wr(spf_pkg::SPF_HDR_VAL_OFS + 12'h020, 32'h0008_2A64);
    mk(32'h0);
    rx_try(42, 1'b0);
    mk(32'hC0A8_642A);
    rx_try(42, 1'b1);
    wr(spf_pkg::SPF_HDR_EN_OFS + 12'h00C, 32'h0000_0101);
    frm[14] = 8'h46;
    rx_try(42, 1'b1);
  endtask
  task automatic t_tx();
    logic [31:0] d;
    logic [15:0] cks;
    wr({spf_pkg::SPF_TX_RAM_PAGE, 6'h00}, 32'h0033_2211);
    slow <= 1'b1;
    wr(spf_pkg::SPF_TX_LEN_OFS, 32'h3);
    rd(spf_pkg::SPF_TX_LEN_OFS, d);
    `CHK("tx_busy", 1'b1, d[31])
    for (int i = 0; i < 40 && mac.txq.size() < 3; i++) @(posedge clock);
    `CHK("tx_bytes", 24'h112233, {mac.txq[0], mac.txq[1], mac.txq[2]})
    `CHK("tx_last", 3, mac.last_at)
    wr(spf_pkg::SPF_TX_LEN_OFS, 32'h0);
    repeat (8) @(posedge clock);
    `CHK("tx_len0", 3, mac.txq.size())
    // software builds a tiny echo reply: type 0, code 0, own checksum, two payload bytes
    cks = ~(16'h0000 + 16'h1234);
    wr({spf_pkg::SPF_TX_RAM_PAGE, 6'h00}, {cks[7:0], cks[15:8], 16'h0000});
    wr({spf_pkg::SPF_TX_RAM_PAGE, 6'h04}, 32'h0000_3412);
    wr(spf_pkg::SPF_TX_LEN_OFS, 32'h6);
    // a length written while busy must be ignored
    wr(spf_pkg::SPF_TX_LEN_OFS, 32'h2);
    for (int i = 0; i < 40 && mac.txq.size() < 9; i++) @(posedge clock);
    `CHK("tx_reply_type", 16'h0000, {mac.txq[3], mac.txq[4]})
    `CHK("tx_reply_cks", 16'hEDCB, {mac.txq[5], mac.txq[6]})
    `CHK("tx_busy_ignored", 9, mac.last_at)
  endtask
  task automatic t_user();
    logic [31:0] d;
    for (int v = 1; v >= 0; v--) begin
      @(posedge clock);
      conn_on <= v[0];
      link_up <= v[0];
      fast_fifo_count <= 16'(v * 5);
      rd(spf_pkg::SPF_USR_CMD_OFS, d);
      `CHK("conn", v[0], d[2])
      rd(spf_pkg::SPF_USR_RST_OFS, d);
      `CHK("link", v[0], d[16])
      rd(spf_pkg::SPF_USR_FF_OFS, d);
      `CHK("fifo", 16'(v * 5), d[15:0])
    end
    @(posedge clock);
    conn_event <= 1'b1;
    @(posedge clock);
    conn_event <= 1'b0;
    repeat (4) @(posedge clock);
    rd(spf_pkg::SPF_USR_INT_OFS, d);
    `CHK("cev_set", 1'b1, d[0])
    wr(spf_pkg::SPF_USR_INT_OFS, 32'h1);
    rd(spf_pkg::SPF_USR_INT_OFS, d);
    `CHK("cev_clr", 1'b0, d[0])
  endtask
  task automatic t_pattern();
    logic [31:0] d;
    int n = 0;
    // counts restart per chunk; chunks up to 4 GB keep 32-bit counts from wrapping
    wr(spf_pkg::SPF_USR_RST_OFS, 32'h1);
    wr(spf_pkg::SPF_USR_CMD_OFS, 32'h3);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      if (gen_valid === 1'b1 && gen_ready === 1'b1) n++;
      gen_ready <= (i < 5);
    end
    #1 `CHK("gen_data", 32'(n), gen_data)
    rd(spf_pkg::SPF_TX_CNT_OFS, d);
    `CHK("tx_count", 32'(4 * n), d)
    chk(32'h0);
    chk(32'h1);
    rd(spf_pkg::SPF_USR_CMD_OFS, d);
    `CHK("ver_ok", 1'b0, d[1])
    rd(spf_pkg::SPF_RX_CNT_OFS, d);
    `CHK("rx_count", 32'h8, d)
    chk(32'h5);
    rd(spf_pkg::SPF_USR_CMD_OFS, d);
    `CHK("ver_err", 1'b1, d[1])
    wr(spf_pkg::SPF_USR_RST_OFS, 32'h1);
    #1 `CHK("gen_restart", 32'h0, gen_data)
    wr(spf_pkg::SPF_USR_CMD_OFS, 32'h1);
    chk(32'h7);
    rd(spf_pkg::SPF_USR_CMD_OFS, d);
    `CHK("gen_run1", 1'b1, d[0])
    `CHK("ver_off", 1'b0, d[1])
  endtask

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_rx();
    t_filter();
    t_tx();
    t_user();
    t_pattern();
    end_of_test();
  end
endmodule
